/* hdl/msd_pkg.sv */
package msd_pkg;

  localparam int MICRO_W = 24;
  localparam int WORD_W = 16;
  localparam int FIELD_W = 4;
  localparam int STORE_LSB = 8;
  localparam int STORE_MSB = 11;
  localparam int SPEC_LSB = 4;
  localparam int SPEC_MSB = 7;
  localparam int NUM_SPEC = 16;

  localparam logic [3:0] ST_IOBUS = 4'h0;
  localparam logic [3:0] ST_MEMADDR = 4'h1;
  localparam logic [3:0] ST_MEMDATA = 4'h2;
  localparam logic [3:0] ST_INSTR = 4'h3;
  localparam logic [3:0] ST_SCR4 = 4'h4;
  localparam logic [3:0] ST_SCR3 = 4'h5;
  localparam logic [3:0] ST_SCR2 = 4'h6;
  localparam logic [3:0] ST_SCR1 = 4'h7;
  localparam logic [3:0] ST_PC = 4'h8;
  localparam logic [3:0] ST_LEFT_EXT = 4'h9;
  localparam logic [3:0] ST_SECOND_EXT = 4'ha;
  localparam logic [3:0] ST_ACC_BY_OPC = 4'hb;
  localparam logic [3:0] ST_ACC_BY_FLAG = 4'hc;
  localparam logic [3:0] ST_ACC_B = 4'hd;
  localparam logic [3:0] ST_ACC_A = 4'he;
  localparam logic [3:0] ST_NOP = 4'hf;

  localparam logic [3:0] SP_SKIP_INV = 4'h0;
  localparam logic [3:0] SP_SHL1 = 4'h1;
  localparam logic [3:0] SP_SHR1 = 4'h2;
  localparam logic [3:0] SP_REPEAT = 4'h3;
  localparam logic [3:0] SP_ADDR_FLAG = 4'h6;
  localparam logic [3:0] SP_ALTER_SKIP = 4'ha;
  localparam logic [3:0] SP_CLEAR_WRITE = 4'hc;
  localparam logic [3:0] SP_READ_WRITE = 4'he;

  localparam int OPC_BIT_ELEVEN = 11;
  localparam int ZERO_TEST_LSB = 1;
  localparam int ZERO_TEST_MSB = 14;
  localparam int RPT_W = 5;
  localparam int RPT_LOAD_MSB = 3;
  localparam int RPT_CARRY_BIT = 4;
  localparam logic [4:0] RPT_RESET = 5'h00;
  localparam int ALTER_SEL_W = 6;
  localparam int ALTER_LOW_BIT = 0;
  localparam int ALTER_HI_LSB = 3;
  localparam int ALTER_HI_MSB = 7;

endpackage

/* hdl/msd_decoder.sv */
`timescale 1ns/1ps
// store and special field decoder; every output is registered, so a
// strobe appears in the cycle after the microword and qualifiers are seen
module msd_decoder
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [msd_pkg::MICRO_W-1:0] micro_word_i,
  input wire logic store_enable_i,
  input wire logic special_enable_i,
  input wire logic phase_two_i,
  input wire logic phase_three_i,
  input wire logic phase_1a_i,
  input wire logic mem_protect_i,
  input wire logic protect_violation_i,
  input wire logic parity_error_i,
  input wire logic memaddr_select_i,
  input wire logic memdata_select_i,
  input wire logic opcode_bit_eleven_i,
  input wire logic [msd_pkg::WORD_W-1:0] result_bus_i,
  input wire logic [msd_pkg::WORD_W-1:0] source_bus_i,
  input wire logic [msd_pkg::WORD_W-1:0] instruction_latch_i,
  input wire logic alu_low_bit_out_i,
  input wire logic clear_addressable_i,
  input wire logic skip_named_i,
  input wire logic skip_true_i,
  input wire logic long_shift_i,
  input wire logic repeat_step_i,
  output logic source_to_iobus_strobe_o,
  output logic instruction_latch_strobe_o,
  output logic memaddr_write_o,
  output logic violation_write_o,
  output logic memdata_write_o,
  output logic program_counter_write_o,
  output logic left_ext_write_strobe_o,
  output logic second_ext_write_o,
  output logic scratch_one_write_o,
  output logic scratch_two_write_o,
  output logic scratch_three_write_o,
  output logic scratch_four_write_o,
  output logic accum_a_write_o,
  output logic accum_b_write_o,
  output logic [msd_pkg::NUM_SPEC-1:0] special_hot_o,
  output logic invert_skip_sense_o,
  output logic shift_left_one_o,
  output logic shift_right_one_o,
  output logic low_word_shift_left_o,
  output logic low_word_shift_right_o,
  output logic load_repeat_count_o,
  output logic [msd_pkg::RPT_W-1:0] repeat_count_o,
  output logic accum_a_addressable_o,
  output logic accum_b_addressable_o,
  output logic memory_read_write_cycle_o,
  output logic memory_clear_write_cycle_o,
  output logic alter_skip_stage_one_o,
  output logic [msd_pkg::ALTER_SEL_W-1:0] alter_skip_select_o
);

  // field extraction
  wire [msd_pkg::FIELD_W-1:0] store_code;
  wire [msd_pkg::FIELD_W-1:0] spec_code;
  assign store_code =
    micro_word_i[msd_pkg::STORE_MSB:msd_pkg::STORE_LSB];
  assign spec_code =
    micro_word_i[msd_pkg::SPEC_MSB:msd_pkg::SPEC_LSB];

  // store decode; the nop code matches no destination so all stay low
  wire st_on;
  assign st_on = store_enable_i && (store_code != msd_pkg::ST_NOP);

  wire io_out_nxt;
  wire instr_nxt;
  wire maddr_nxt;
  wire viol_nxt;
  wire mdata_nxt;
  wire pc_nxt;
  wire lext_nxt;
  wire sext_nxt;
  wire scr1_nxt;
  wire scr2_nxt;
  wire scr3_nxt;
  wire scr4_nxt;
  wire acc_a_nxt;
  wire acc_b_nxt;

  assign io_out_nxt = st_on && (store_code == msd_pkg::ST_IOBUS);
  // the instruction latch samples only at phase two
  assign instr_nxt = st_on && (store_code == msd_pkg::ST_INSTR)
    && phase_two_i;
  assign maddr_nxt = st_on && (store_code == msd_pkg::ST_MEMADDR)
    && memaddr_select_i && phase_three_i;
  // violation copy is skipped outside 1A or once protection has tripped
  assign viol_nxt = maddr_nxt && phase_1a_i && mem_protect_i
    && !protect_violation_i && !parity_error_i;
  assign mdata_nxt = st_on && (store_code == msd_pkg::ST_MEMDATA)
    && memdata_select_i && phase_three_i;
  assign pc_nxt = st_on && (store_code == msd_pkg::ST_PC);
  assign lext_nxt = st_on && (store_code == msd_pkg::ST_LEFT_EXT);
  assign sext_nxt =
    st_on && (store_code == msd_pkg::ST_SECOND_EXT);
  assign scr1_nxt = st_on && (store_code == msd_pkg::ST_SCR1);
  assign scr2_nxt = st_on && (store_code == msd_pkg::ST_SCR2);
  assign scr3_nxt = st_on && (store_code == msd_pkg::ST_SCR3);
  assign scr4_nxt = st_on && (store_code == msd_pkg::ST_SCR4);

  logic acc_a_flag_r;
  logic acc_b_flag_r;

  wire by_opc;
  wire by_flag;
  assign by_opc = st_on && (store_code == msd_pkg::ST_ACC_BY_OPC);
  assign by_flag = st_on && (store_code == msd_pkg::ST_ACC_BY_FLAG);

  // both flags set cannot come from one set event; should it happen,
  // accumulator a wins so that only one destination is ever written
  assign acc_a_nxt = (st_on && (store_code == msd_pkg::ST_ACC_A))
    || (by_opc && !opcode_bit_eleven_i)
    || (by_flag && acc_a_flag_r);
  assign acc_b_nxt = (st_on && (store_code == msd_pkg::ST_ACC_B))
    || (by_opc && opcode_bit_eleven_i)
    || (by_flag && !acc_a_flag_r && acc_b_flag_r);

  // special decode, one line per code
  wire [msd_pkg::NUM_SPEC-1:0] spec_hot_nxt;
  genvar g;
  generate
    for (g = 0; g < msd_pkg::NUM_SPEC; g = g + 1)
    begin : g_spec
      assign spec_hot_nxt[g] = special_enable_i
        && (spec_code == (msd_pkg::FIELD_W)'(g));
    end
  endgenerate

  wire skip_inv_nxt;
  wire shl_nxt;
  wire shr_nxt;
  wire rpt_load;
  wire flag_set_code;
  wire asg_nxt;
  wire rw_nxt;
  wire clr_wr_nxt;

  assign skip_inv_nxt = spec_hot_nxt[msd_pkg::SP_SKIP_INV];
  assign shl_nxt = spec_hot_nxt[msd_pkg::SP_SHL1];
  assign shr_nxt = spec_hot_nxt[msd_pkg::SP_SHR1];
  assign rpt_load = spec_hot_nxt[msd_pkg::SP_REPEAT];
  assign flag_set_code = spec_hot_nxt[msd_pkg::SP_ADDR_FLAG];
  assign asg_nxt = spec_hot_nxt[msd_pkg::SP_ALTER_SKIP];
  // the fetch is not gated by the addressable flags; it runs anyway
  assign rw_nxt = spec_hot_nxt[msd_pkg::SP_READ_WRITE];
  // clear/write is destructive, so it needs a named and true skip test
  assign clr_wr_nxt = spec_hot_nxt[msd_pkg::SP_CLEAR_WRITE]
    && skip_named_i && skip_true_i;

  // addressable flags
  wire zero_mid;
  wire set_a;
  wire set_b;
  wire acc_a_flag_nxt;
  wire acc_b_flag_nxt;
  assign zero_mid = ~|result_bus_i[msd_pkg::ZERO_TEST_MSB:
    msd_pkg::ZERO_TEST_LSB];
  assign set_a = flag_set_code && zero_mid && !alu_low_bit_out_i;
  assign set_b = flag_set_code && zero_mid && alu_low_bit_out_i;
  // a set in the clearing cycle is kept
  assign acc_a_flag_nxt = set_a || (acc_a_flag_r && !clear_addressable_i);
  assign acc_b_flag_nxt = set_b || (acc_b_flag_r && !clear_addressable_i);

  // repeat counter: load wins over a step in the same cycle
  logic [msd_pkg::RPT_W-1:0] rpt_r;
  wire [msd_pkg::RPT_W-1:0] rpt_nxt;
  assign rpt_nxt = rpt_load
    ? {1'b0, source_bus_i[msd_pkg::RPT_LOAD_MSB:0]}
    : (repeat_step_i && !rpt_r[msd_pkg::RPT_CARRY_BIT])
      ? rpt_r + 5'h01
      : rpt_r;

  wire [msd_pkg::ALTER_SEL_W-1:0] alter_sel_nxt;
  assign alter_sel_nxt = asg_nxt
    ? {instruction_latch_i[msd_pkg::ALTER_HI_MSB:msd_pkg::ALTER_HI_LSB],
       instruction_latch_i[msd_pkg::ALTER_LOW_BIT]}
    : 6'h00;

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      source_to_iobus_strobe_o <= 1'b0;
      instruction_latch_strobe_o <= 1'b0;
      memaddr_write_o <= 1'b0;
      violation_write_o <= 1'b0;
      memdata_write_o <= 1'b0;
      program_counter_write_o <= 1'b0;
      left_ext_write_strobe_o <= 1'b0;
      second_ext_write_o <= 1'b0;
      scratch_one_write_o <= 1'b0;
      scratch_two_write_o <= 1'b0;
      scratch_three_write_o <= 1'b0;
      scratch_four_write_o <= 1'b0;
      accum_a_write_o <= 1'b0;
      accum_b_write_o <= 1'b0;
    end
    else
    begin
      source_to_iobus_strobe_o <= io_out_nxt;
      instruction_latch_strobe_o <= instr_nxt;
      memaddr_write_o <= maddr_nxt;
      violation_write_o <= viol_nxt;
      memdata_write_o <= mdata_nxt;
      program_counter_write_o <= pc_nxt;
      left_ext_write_strobe_o <= lext_nxt;
      second_ext_write_o <= sext_nxt;
      scratch_one_write_o <= scr1_nxt;
      scratch_two_write_o <= scr2_nxt;
      scratch_three_write_o <= scr3_nxt;
      scratch_four_write_o <= scr4_nxt;
      accum_a_write_o <= acc_a_nxt;
      accum_b_write_o <= acc_b_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      special_hot_o <= 16'h0000;
      invert_skip_sense_o <= 1'b0;
      shift_left_one_o <= 1'b0;
      shift_right_one_o <= 1'b0;
      low_word_shift_left_o <= 1'b0;
      low_word_shift_right_o <= 1'b0;
      load_repeat_count_o <= 1'b0;
      memory_read_write_cycle_o <= 1'b0;
      memory_clear_write_cycle_o <= 1'b0;
      alter_skip_stage_one_o <= 1'b0;
      alter_skip_select_o <= 6'h00;
    end
    else
    begin
      special_hot_o <= spec_hot_nxt;
      invert_skip_sense_o <= skip_inv_nxt;
      shift_left_one_o <= shl_nxt;
      shift_right_one_o <= shr_nxt;
      low_word_shift_left_o <= shl_nxt && long_shift_i;
      low_word_shift_right_o <= shr_nxt && long_shift_i;
      load_repeat_count_o <= rpt_load;
      memory_read_write_cycle_o <= rw_nxt;
      memory_clear_write_cycle_o <= clr_wr_nxt;
      alter_skip_stage_one_o <= asg_nxt;
      alter_skip_select_o <= alter_sel_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      acc_a_flag_r <= 1'b0;
      acc_b_flag_r <= 1'b0;
      rpt_r <= msd_pkg::RPT_RESET;
    end
    else
    begin
      acc_a_flag_r <= acc_a_flag_nxt;
      acc_b_flag_r <= acc_b_flag_nxt;
      rpt_r <= rpt_nxt;
    end
  end

  assign accum_a_addressable_o = acc_a_flag_r;
  assign accum_b_addressable_o = acc_b_flag_r;
  assign repeat_count_o = rpt_r;

endmodule

/* verif/msd_cstore.sv */
`timescale 1ns/1ps
// control store word: the unused bits hold a fixed busy pattern so a
// decoder that reads the wrong bits sees the wrong code
module msd_cstore
(
  input wire logic [3:0] st_i,
  input wire logic [3:0] sp_i,
  output logic [23:0] word_o
);
  assign word_o = {12'h5a5, st_i, sp_i, 4'h9};
endmodule

/* verif/msd_chk.sv */
`timescale 1ns/1ps
module msd_chk
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [msd_pkg::MICRO_W-1:0] micro_word_i,
  input wire logic store_enable_i,
  input wire logic phase_two_i,
  input wire logic phase_three_i,
  input wire logic phase_1a_i,
  input wire logic mem_protect_i,
  input wire logic protect_violation_i,
  input wire logic parity_error_i,
  input wire logic memaddr_select_i,
  input wire logic memdata_select_i,
  input wire logic opcode_bit_eleven_i,
  input wire logic source_to_iobus_strobe_o,
  input wire logic instruction_latch_strobe_o,
  input wire logic memaddr_write_o,
  input wire logic violation_write_o,
  input wire logic memdata_write_o,
  input wire logic program_counter_write_o,
  input wire logic left_ext_write_strobe_o,
  input wire logic second_ext_write_o,
  input wire logic scratch_one_write_o,
  input wire logic scratch_two_write_o,
  input wire logic scratch_three_write_o,
  input wire logic scratch_four_write_o,
  input wire logic accum_a_write_o,
  input wire logic accum_b_write_o
);
  wire [3:0] st = micro_word_i[11:8];
  wire se = store_enable_i;
  wire [12:0] stb = {source_to_iobus_strobe_o, instruction_latch_strobe_o,
    memaddr_write_o, memdata_write_o, program_counter_write_o,
    left_ext_write_strobe_o, second_ext_write_o, scratch_one_write_o,
    scratch_two_write_o, scratch_three_write_o, scratch_four_write_o,
    accum_a_write_o, accum_b_write_o};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  iobus_strobe_a:
    assert property (1'b1 |=> source_to_iobus_strobe_o ==
      $past(se && st == 4'h0)) else $error("iobus strobe");
  instr_latch_a:
    assert property (1'b1 |=> instruction_latch_strobe_o ==
      $past(se && st == 4'h3 && phase_two_i)) else $error("ilatch");
  mem_addr_a:
    assert property (1'b1 |=> memaddr_write_o == $past(se && st == 4'h1
      && phase_three_i && memaddr_select_i)) else $error("memaddr");
  viol_copy_a:
    assert property (1'b1 |=> violation_write_o == $past(se && st == 4'h1
      && phase_three_i && memaddr_select_i && phase_1a_i && mem_protect_i
      && !protect_violation_i && !parity_error_i)) else $error("viol");
  mem_data_a:
    assert property (1'b1 |=> memdata_write_o == $past(se && st == 4'h2
      && phase_three_i && memdata_select_i)) else $error("memdata");
  single_dest_a:
    assert property ($onehot0(stb)) else $error("two strobes");
  store_off_a:
    assert property (!se || st == 4'hf |=> stb == 13'h0000 &&
      !violation_write_o) else $error("strobe while off");
  accum_pick_a:
    assert property (se && st == 4'hb |=> accum_b_write_o ==
      $past(opcode_bit_eleven_i) && accum_a_write_o ==
      !$past(opcode_bit_eleven_i)) else $error("accum pick");
endmodule
bind msd_decoder msd_chk chk_u (.*);

/* verif/msd_decoder_tb.sv */
`timescale 1ns/1ps
module msd_decoder_tb;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic store_enable_i = 1'b0, special_enable_i = 1'b0;
  logic phase_two_i = 1'b0, phase_three_i = 1'b0, phase_1a_i = 1'b0;
  logic mem_protect_i = 1'b0, protect_violation_i = 1'b0;
  logic parity_error_i = 1'b0, memaddr_select_i = 1'b0;
  logic memdata_select_i = 1'b0, opcode_bit_eleven_i = 1'b0;
  logic alu_low_bit_out_i = 1'b0, clear_addressable_i = 1'b0;
  logic skip_named_i = 1'b0, skip_true_i = 1'b0;
  logic long_shift_i = 1'b0, repeat_step_i = 1'b0;
  logic [15:0] result_bus_i = 16'h0000, source_bus_i = 16'h0000;
  logic [15:0] instruction_latch_i = 16'h0000;
  logic [3:0] st = 4'hf, sp = 4'hf;
  logic [23:0] micro_word_i;
  logic source_to_iobus_strobe_o, instruction_latch_strobe_o;
  logic memaddr_write_o, violation_write_o, memdata_write_o;
  logic program_counter_write_o, left_ext_write_strobe_o;
  logic second_ext_write_o, scratch_one_write_o, scratch_two_write_o;
  logic scratch_three_write_o, scratch_four_write_o;
  logic accum_a_write_o, accum_b_write_o, invert_skip_sense_o;
  logic shift_left_one_o, shift_right_one_o, low_word_shift_left_o;
  logic low_word_shift_right_o, load_repeat_count_o;
  logic accum_a_addressable_o, accum_b_addressable_o;
  logic memory_read_write_cycle_o, memory_clear_write_cycle_o;
  logic alter_skip_stage_one_o;
  logic [15:0] special_hot_o;
  logic [4:0] repeat_count_o;
  logic [5:0] alter_skip_select_o;
  logic [8:0] ev;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  // store code beside the destination strobes it should raise
  logic [19:0] rows [16] = '{20'h02000, 20'h10801, 20'h20400, 20'h31000,
    20'h40008, 20'h50010, 20'h60020, 20'h70040, 20'h80200, 20'h90100,
    20'ha0080, 20'hb0004, 20'hc0000, 20'hd0002, 20'he0004, 20'hf0000};
  wire [13:0] stb = {source_to_iobus_strobe_o, instruction_latch_strobe_o,
    memaddr_write_o, memdata_write_o, program_counter_write_o,
    left_ext_write_strobe_o, second_ext_write_o, scratch_one_write_o,
    scratch_two_write_o, scratch_three_write_o, scratch_four_write_o,
    accum_a_write_o, accum_b_write_o, violation_write_o};
  wire [8:0] spv = {invert_skip_sense_o, shift_left_one_o, shift_right_one_o,
    load_repeat_count_o, alter_skip_stage_one_o, memory_read_write_cycle_o,
    memory_clear_write_cycle_o, low_word_shift_left_o, low_word_shift_right_o};
  msd_decoder dut_u (.*);
  msd_cstore cs_u (.st_i(st), .sp_i(sp), .word_o(micro_word_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // outputs are registered: look one edge after the drive edge
  task automatic tst(input string n, input logic [15:0] e);
    @(posedge ref_clk_i);
    #1;
    chk(n, e, {2'b00, stb});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 500)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    tst("idle", 16'h0000);
    @(posedge ref_clk_i);
    {store_enable_i, special_enable_i, phase_two_i, phase_three_i} <= 4'hf;
    {phase_1a_i, mem_protect_i, memaddr_select_i, memdata_select_i} <= 4'hf;
    {clear_addressable_i, skip_named_i, skip_true_i, long_shift_i} <= 4'hf;
    source_bus_i <= 16'hfff5;
    instruction_latch_i <= 16'h0089;
    result_bus_i <= 16'h8001;
    for (int i = 0; i < 16; i++)
    begin
      st <= rows[i][19:16];
      sp <= i[3:0];
      tst("store", rows[i][15:0]);
      chk("hot", 16'h0001 << i, special_hot_o);
      ev = {i == 0, i == 1, i == 2, i == 3, i == 10, i == 14, i == 12,
        i == 1, i == 2};
      chk("ctl", {7'h00, ev},
        {7'h00, spv});
      chk("alt", (i == 10) ? 16'h0023 : 16'h0000,
        {10'h000, alter_skip_select_o});
      if (i == 3)
        chk("rpt", 16'h0005, {11'h000, repeat_count_o});
      if (i == 6)
        chk("flag_a", 16'h0001,
          {15'h0000, accum_a_addressable_o});
      @(posedge ref_clk_i);
    end
    st <= 4'h1;
    parity_error_i <= 1'b1;
    tst("parity", 16'h0800);
    @(posedge ref_clk_i);
    memaddr_select_i <= 1'b0;
    tst("msel", 16'h0000);
    @(posedge ref_clk_i);
    st <= 4'h3;
    phase_two_i <= 1'b0;
    tst("ph2", 16'h0000);
    @(posedge ref_clk_i);
    st <= 4'h2;
    phase_three_i <= 1'b0;
    tst("ph3", 16'h0000);
    @(posedge ref_clk_i);
    {phase_two_i, phase_three_i, opcode_bit_eleven_i} <= 3'h7;
    st <= 4'hb;
    sp <= 4'h6;
    {alu_low_bit_out_i, clear_addressable_i, skip_true_i} <= 3'h4;
    tst("acc_opc", 16'h0002);
    chk("flag_b", 16'h0001, {15'h0000, accum_b_addressable_o});
    // the flag set above now picks the destination of store by flag
    @(posedge ref_clk_i);
    st <= 4'hc;
    sp <= 4'hc;
    tst("acc_flag", 16'h0002);
    chk("clrwr_off", 16'h0000,
      {15'h0000, memory_clear_write_cycle_o});
    @(posedge ref_clk_i);
    sp <= 4'he;
    tst("rw_store", 16'h0002);
    chk("rw_fetch", 16'h0001,
      {15'h0000, memory_read_write_cycle_o});
    @(posedge ref_clk_i);
    sp <= 4'h3;
    source_bus_i <= 16'h000f;
    tst("rnop", 16'h0002);
    chk("rpt_f", 16'h000f, {11'h000, repeat_count_o});
    @(posedge ref_clk_i);
    sp <= 4'hf;
    repeat_step_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("rpt_top", 16'h0010, {11'h000, repeat_count_o});
    @(posedge ref_clk_i);
    sp <= 4'h3;
    source_bus_i <= 16'h0000;
    tst("rld", 16'h0002);
    chk("rpt_clr", 16'h0000, {11'h000, repeat_count_o});
    @(posedge ref_clk_i);
    {store_enable_i, special_enable_i} <= 2'h0;
    st <= 4'h0;
    tst("off", 16'h0000);
    chk("hot_off", 16'h0000, special_hot_o);
    tally_and_finish();
  end
endmodule
